// [logic/increment_file_op_pkg.sv]
// ifro_pkg: register map, field positions, reset values and opcode constants
// for the increment-file execution block.
// assumes a 32-bit AHB-Lite register bus with byte addressing.
package ifro_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_WREG = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_INDEX = 8'h14;
    localparam logic [7:0] OFS_MADDR = 8'h18;
    localparam logic [7:0] OFS_MDATA = 8'h1C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int ST_C_BIT = 0;
    localparam int ST_DIGIT_CARRY_BIT = 1;
    localparam int ST_Z_BIT = 2;
    localparam int ST_OVERFLOW_BIT = 3;
    localparam int ST_N_BIT = 4;
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_ILL_BIT = 8;
    localparam int INSTR_D_BIT = 9;
    localparam int INSTR_A_BIT = 8;

    // ------------------------------------------------------------------
    // reset values and decode constants
    // ------------------------------------------------------------------
    localparam logic [15:0] INSTR_RST = 16'h0000;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [11:0] INDEX_RST = 12'h000;
    localparam logic [11:0] MADDR_RST = 12'h000;
    localparam logic [5:0] OPCODE_INCREMENT = 6'h0A;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam int MEM_DEPTH = 4096;

    // quarter-cycle sequencer, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_Q1 = 5'b00010,
        ST_Q2 = 5'b00100,
        ST_Q3 = 5'b01000,
        ST_Q4 = 5'b10000
    } ifro_state_type;
endpackage : ifro_pkg

// [logic/increment_file_op_core.sv]
// ifro_core: executes the increment-file instruction against a local data
// memory; registers and memory are reachable over an AHB-Lite slave port, the operand, result and address latches are not.
// assumes a single master, single word transfers, and clk_sys at 25 MHz.
//
// What this block does
// - read byte, add one, update five flags
// - destination bit 0 writes accumulator only
// - destination bit 1 writes back to memory
// - access bit 0 uses fixed shared bank
// - access bit 1 uses bank select register
// - extended mode, access bit 0, low addresses use indexed offset
`timescale 1ns/1ps
module ifro_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    ifro_pkg::ifro_state_type state_r, state_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [3:0] bank_select_register_r, bank_select_register_nxt;
    logic [7:0] wreg_r, wreg_nxt;
    logic [4:0] flags_r, flags_nxt;
    logic illegal_r, illegal_nxt;
    logic ext_en_r, ext_en_nxt;
    logic [11:0] index_r, index_nxt;
    logic [11:0] maddr_r, maddr_nxt;
    logic [11:0] exec_addr_r, exec_addr_nxt;
    logic exec_dest_r, exec_dest_nxt;
    logic [7:0] operand_r, operand_nxt;
    logic [7:0] result_r, result_nxt;
    logic [7:0] bus_addr_r, bus_addr_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic hready_r, hready_nxt;
    logic hresp_r;

    logic [7:0] mem [0:ifro_pkg::MEM_DEPTH-1];
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;

    logic bus_sel;
    logic busy;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] fsel;
    logic [31:0] rd_mux;

    assign bus_sel = hsel & htrans[1] & hready;
    assign busy = (state_r != ifro_pkg::ST_IDLE);
    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = hresp_r;
    assign fsel = instr_r[7:0];

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (bus_addr_r)
            ifro_pkg::OFS_CTRL: begin
                rd_mux[ifro_pkg::CTRL_EXT_BIT] = ext_en_r;
            end
            ifro_pkg::OFS_INSTR: rd_mux[15:0] = instr_r;
            ifro_pkg::OFS_BANK: rd_mux[3:0] = bank_select_register_r;
            ifro_pkg::OFS_WREG: rd_mux[7:0] = wreg_r;
            ifro_pkg::OFS_STATUS: begin
                rd_mux[4:0] = flags_r;
                rd_mux[ifro_pkg::ST_BUSY_BIT] = busy;
                rd_mux[ifro_pkg::ST_ILL_BIT] = illegal_r;
            end
            ifro_pkg::OFS_INDEX: rd_mux[11:0] = index_r;
            ifro_pkg::OFS_MADDR: rd_mux[11:0] = maddr_r;
            ifro_pkg::OFS_MDATA: rd_mux[7:0] = mem[maddr_r];
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------
    // next-state logic: bus slave and quarter sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        bank_select_register_nxt = bank_select_register_r;
        wreg_nxt = wreg_r;
        flags_nxt = flags_r;
        illegal_nxt = illegal_r;
        ext_en_nxt = ext_en_r;
        index_nxt = index_r;
        maddr_nxt = maddr_r;
        exec_addr_nxt = exec_addr_r;
        exec_dest_nxt = exec_dest_r;
        operand_nxt = operand_r;
        result_nxt = result_r;
        bus_addr_nxt = bus_addr_r;
        hrdata_nxt = hrdata_r;
        hready_nxt = 1'b1;
        wr_pend_nxt = 1'b0;
        rd_pend_nxt = 1'b0;
        mem_we = 1'b0;
        mem_waddr = maddr_r;
        mem_wdata = hwdata[7:0];
        sum = {1'b0, operand_r} + 9'h001;
        low_sum = {1'b0, operand_r[3:0]} + 5'h01;

        // address phase; reads take one wait state so a write just before
        // them is always seen
        if (bus_sel) begin
            bus_addr_nxt = haddr[7:0];
            wr_pend_nxt = hwrite;
            rd_pend_nxt = ~hwrite;
            hready_nxt = hwrite;
        end
        if (rd_pend_r) begin
            hrdata_nxt = rd_mux;
        end

        // data phase writes; state is frozen while an instruction runs
        if (wr_pend_r && !busy) begin
            unique case (bus_addr_r)
                ifro_pkg::OFS_CTRL: begin
                    ext_en_nxt = hwdata[ifro_pkg::CTRL_EXT_BIT];
                    if (hwdata[ifro_pkg::CTRL_START_BIT]) begin
                        state_nxt = ifro_pkg::ST_Q1;
                        illegal_nxt = 1'b0;
                    end
                end
                ifro_pkg::OFS_INSTR: instr_nxt = hwdata[15:0];
                ifro_pkg::OFS_BANK: bank_select_register_nxt = hwdata[3:0];
                ifro_pkg::OFS_WREG: wreg_nxt = hwdata[7:0];
                ifro_pkg::OFS_STATUS: begin
                    flags_nxt = hwdata[4:0];
                    illegal_nxt = hwdata[ifro_pkg::ST_ILL_BIT];
                end
                ifro_pkg::OFS_INDEX: index_nxt = hwdata[11:0];
                ifro_pkg::OFS_MADDR: maddr_nxt = hwdata[11:0];
                ifro_pkg::OFS_MDATA: mem_we = 1'b1;
                default: mem_we = 1'b0;
            endcase
        end

        unique case (state_r)
            ifro_pkg::ST_IDLE: begin
            end
            ifro_pkg::ST_Q1: begin
                // decode the single word and resolve the operand address
                if (instr_r[15:10] != ifro_pkg::OPCODE_INCREMENT) begin
                    illegal_nxt = 1'b1;
                    state_nxt = ifro_pkg::ST_IDLE;
                end else begin
                    state_nxt = ifro_pkg::ST_Q2;
                end
                exec_dest_nxt = instr_r[ifro_pkg::INSTR_D_BIT];
                if (instr_r[ifro_pkg::INSTR_A_BIT]) begin
                    exec_addr_nxt = {bank_select_register_r, fsel};
                end else if (ext_en_r && fsel <= ifro_pkg::INDEXED_MAX) begin
                    // index base plus literal offset, wrapping in memory
                    exec_addr_nxt = index_r + {4'h0, fsel};
                end else if (fsel < ifro_pkg::ACCESS_SPLIT) begin
                    exec_addr_nxt = {4'h0, fsel};
                end else begin
                    exec_addr_nxt = {ifro_pkg::ACCESS_HIGH_BANK, fsel};
                end
            end
            ifro_pkg::ST_Q2: begin
                operand_nxt = mem[exec_addr_r];
                state_nxt = ifro_pkg::ST_Q3;
            end
            ifro_pkg::ST_Q3: begin
                result_nxt = sum[7:0];
                flags_nxt[ifro_pkg::ST_C_BIT] = sum[8];
                flags_nxt[ifro_pkg::ST_DIGIT_CARRY_BIT] = low_sum[4];
                flags_nxt[ifro_pkg::ST_Z_BIT] = (sum[7:0] == 8'h00);
                flags_nxt[ifro_pkg::ST_N_BIT] = sum[7];
                flags_nxt[ifro_pkg::ST_OVERFLOW_BIT] = ~operand_r[7] & sum[7];
                state_nxt = ifro_pkg::ST_Q4;
            end
            ifro_pkg::ST_Q4: begin
                if (exec_dest_r) begin
                    mem_we = 1'b1;
                    mem_waddr = exec_addr_r;
                    mem_wdata = result_r;
                end else begin
                    wreg_nxt = result_r;
                end
                state_nxt = ifro_pkg::ST_IDLE;
            end
            default: state_nxt = ifro_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= ifro_pkg::ST_IDLE;
            instr_r <= ifro_pkg::INSTR_RST;
            bank_select_register_r <= ifro_pkg::BANK_RST;
            wreg_r <= ifro_pkg::WREG_RST;
            flags_r <= ifro_pkg::FLAGS_RST;
            illegal_r <= 1'b0;
            ext_en_r <= 1'b0;
            index_r <= ifro_pkg::INDEX_RST;
            maddr_r <= ifro_pkg::MADDR_RST;
            exec_addr_r <= 12'h000;
            exec_dest_r <= 1'b0;
            operand_r <= 8'h00;
            result_r <= 8'h00;
            bus_addr_r <= 8'h00;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            hrdata_r <= 32'h00000000;
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            instr_r <= instr_nxt;
            bank_select_register_r <= bank_select_register_nxt;
            wreg_r <= wreg_nxt;
            flags_r <= flags_nxt;
            illegal_r <= illegal_nxt;
            ext_en_r <= ext_en_nxt;
            index_r <= index_nxt;
            maddr_r <= maddr_nxt;
            exec_addr_r <= exec_addr_nxt;
            exec_dest_r <= exec_dest_nxt;
            operand_r <= operand_nxt;
            result_r <= result_nxt;
            bus_addr_r <= bus_addr_nxt;
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
            hrdata_r <= hrdata_nxt;
            hready_r <= hready_nxt;
            hresp_r <= 1'b0;
        end
    end

    // memory contents are not reset; software loads what it needs
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule : ifro_core

// [dv/increment_file_op_checker.sv]
// ifro_checker: bus timing checks on the ports of ifro_core.
// assumes one master, hready tied to hreadyout.
`timescale 1ns/1ps
module ifro_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic take;
    assign take = hsel && htrans[1] && hready;
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_low_once: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    a_data_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (take && !hwrite && haddr[7:0] >= 8'h20
        |-> ##2 hrdata == 32'h0) else $error("unmapped read not zero");
    a_ready_release: assert property ($rose(resetn) |-> hreadyout && hrdata == 32'h0)
        else $error("bus not idle after reset");
endmodule : ifro_checker

bind ifro_core ifro_checker u_ifro_checker (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

// [dv/increment_file_op_core_tb.sv]
// ifro_core_tb: runs increments over the register bus and checks results.
// assumes ifro_core alone on the bus, hready looped from hreadyout.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ifro_core_tb;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h187FDACA;
    logic rd_pend = 1'b0;
    logic [31:0] exp_q[$];
    string name_q[$];
    logic [7:0] f, op, w0, res;
    logic d, a, ext;
    logic [3:0] bank;
    logic [11:0] idx, ma;
    logic [31:0] st;

    ifro_core u_ifro_core (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    initial forever #20 clk_sys = ~clk_sys;

    task summarize();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // read monitor: one note per read, compared when the data phase ends
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (rd_pend && hreadyout === 1'b1) begin
            `CHK(name_q[0], exp_q[0], hrdata)
            void'(exp_q.pop_front());
            void'(name_q.pop_front());
        end
        if (hsel && htrans[1] && !hwrite && hreadyout)
            rd_pend <= 1'b1;
        else if (hreadyout === 1'b1)
            rd_pend <= 1'b0;
        // a hang counts as a mismatch and ends the run here
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // caller enters right after a rising edge
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= dt;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        bus(1'b1, ad, dt);
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        bus(1'b0, ad, 32'h0);
    endtask : rd

    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        hsel <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), 32'h0, "reset value");
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0, "unmapped");
        // wrong opcode only flags, accumulator untouched
        wr(ifro_pkg::OFS_INSTR, 32'h2400);
        wr(ifro_pkg::OFS_CTRL, 32'h1);
        repeat (5) @(posedge clk_sys);
        rd(ifro_pkg::OFS_STATUS, 32'h100, "illegal");
        rd(ifro_pkg::OFS_WREG, 32'h0, "wreg kept");
        // software may load the flags and the illegal marker while idle
        wr(ifro_pkg::OFS_STATUS, 32'h11F);
        rd(ifro_pkg::OFS_STATUS, 32'h11F, "status written");
        for (int i = 0; i < 16; i++) begin
            f = 8'($random(seed));
            if (i[2])
                f = f % 8'h60;
            d = i[3];
            a = i[0];
            ext = i[1];
            bank = 4'($random(seed));
            idx = 12'($random(seed));
            w0 = 8'($random(seed));
            op = (i < 3) ? 8'(24'hFF7F0F >> (i * 8)) : 8'($random(seed));
            ma = a ? {bank, f} : (ext && f <= 8'h5F) ? idx + 12'(f) : {f < 8'h60 ? 4'h0 : 4'hF, f};
            res = op + 8'h01;
            st = {27'h0, res[7], op == 8'h7F, res == 8'h0, op[3:0] == 4'hF, op == 8'hFF};
            wr(ifro_pkg::OFS_MADDR, 32'(ma));
            wr(ifro_pkg::OFS_MDATA, 32'(op));
            wr(ifro_pkg::OFS_WREG, 32'(w0));
            wr(ifro_pkg::OFS_BANK, 32'(bank));
            wr(ifro_pkg::OFS_INDEX, 32'(idx));
            wr(ifro_pkg::OFS_INSTR, {16'h0, ifro_pkg::OPCODE_INCREMENT, d, a, f});
            wr(ifro_pkg::OFS_CTRL, {30'h0, ext, 1'b1});
            // lands while busy, so it must be dropped
            wr(ifro_pkg::OFS_WREG, 32'h5A);
            repeat (4) @(posedge clk_sys);
            rd(ifro_pkg::OFS_WREG, 32'(d ? w0 : res), "accumulator");
            rd(ifro_pkg::OFS_MDATA, 32'(d ? res : op), "memory byte");
            rd(ifro_pkg::OFS_STATUS, st, "flags");
        end
        // the last pass ran in extended mode; registers keep what was written
        rd(ifro_pkg::OFS_CTRL, 32'h2, "extended mode");
        rd(ifro_pkg::OFS_BANK, 32'(bank), "bank register");
        rd(ifro_pkg::OFS_INDEX, 32'(idx), "index base");
        rd(ifro_pkg::OFS_MADDR, 32'(ma), "memory pointer");
        @(posedge clk_sys);
        summarize();
    end
endmodule : ifro_core_tb
